// >>> hdl/stc_regs.svh
// register offsets, field positions, reset values and timing counts of the timer
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
`define STC_CTRL_IDX 12'hfcd
`define STC_CNTL_IDX 12'hfce
`define STC_CNTH_IDX 12'hfcf
`define STC_STAT_IDX 12'hfd0
`define STC_MASK_IDX 12'hfd1
`define STC_RUN_BIT 0
`define STC_WIDE_BIT 1
`define STC_SYNCN_BIT 2
`define STC_OSCEN_BIT 3
`define STC_PS_LSB 4
`define STC_CS_LSB 6
`define STC_OVF_BIT 0
`define STC_CTRL_RST 8'h00
`define STC_INSTR_DIV 4
`endif

// >>> hdl/stc_pkg.sv
// types shared by the timer block
package stc_pkg;
  typedef enum logic [1:0] {
    STC_SRC_INSTR = 2'b00,
    STC_SRC_SYS = 2'b01,
    STC_SRC_EXT = 2'b10,
    STC_SRC_RSVD = 2'b11
  } stc_src_type;
  typedef enum logic [1:0] {
    STC_BUS_IDLE = 2'b00,
    STC_BUS_ACK = 2'b01
  } stc_bus_type;
  typedef struct packed {
    stc_src_type source;
    logic [1:0] prescale;
    logic osc_en;
    logic sync_n;
    logic wide;
    logic run;
  } stc_ctrl_type;
endpackage

// >>> hdl/stc_timer.sv
// sixteen bit timer/counter with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_timer
  import stc_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_count_pin,
  input wire logic low_power_crystal_osc,
  input wire logic special_event_trigger,
  input wire logic companion_oscillator_enable,
  output logic crystal_driver_power,
  output logic alt_sys_clock_source,
  output logic [CNT_W-1:0] count,
  output logic irq
);
  // elaboration guard: the byte registers only cover sixteen bits
  if (CNT_W != 16)
  begin : g_width_check
    $error("count width must be 16");
  end

  // one cycle waitrequest slave
  stc_bus_type bus_q, bus_d;
  stc_ctrl_type ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0] hbuf_q, hbuf_d;
  logic [7:0] wbuf_q, wbuf_d;
  logic stat_q, stat_d;
  logic mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic ps_q, ps_d;
  logic [2:0] pre_q, pre_d;
  logic [1:0] idiv_q, idiv_d;
  logic ext_m_q, ext_s_q, ext_p_q;
  logic ext_raw, ext_in, ext_rise, tick, pre_full, ovf;
  logic req, ack, wr_ctrl, wr_lo, wr_hi, wr_stat, wr_mask, rd_lo;
  logic wait_q, wait_d;
  logic [7:0] wbyte;
  logic [15:0] cnt_inc;
  logic crys_q, crys_d, alt_q, alt_d;

  function automatic logic [2:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'b01: pre_limit = 3'h1;
      2'b10: pre_limit = 3'h3;
      2'b11: pre_limit = 3'h7;
      default: pre_limit = 3'h0;
    endcase
  endfunction

  // access strobes
  assign req = (avs_read | avs_write) & (bus_q == STC_BUS_IDLE);
  // writes land on the edge where waitrequest is seen low
  assign ack = (avs_read | avs_write) & (bus_q == STC_BUS_ACK);
  assign wbyte = avs_writedata[7:0];
  assign wr_ctrl = ack & avs_write & (avs_address == `STC_CTRL_IDX);
  assign wr_lo = ack & avs_write & (avs_address == `STC_CNTL_IDX);
  assign wr_hi = ack & avs_write & (avs_address == `STC_CNTH_IDX);
  assign wr_stat = ack & avs_write & (avs_address == `STC_STAT_IDX);
  assign wr_mask = ack & avs_write & (avs_address == `STC_MASK_IDX);
  assign rd_lo = req & avs_read & (avs_address == `STC_CNTL_IDX);

  // external clock source and synchronizer
  assign ext_raw = ctrl_q.osc_en ? low_power_crystal_osc : external_count_pin;
  assign ext_in = ctrl_q.sync_n ? ext_raw : ext_s_q;
  assign ext_rise = ext_in & ~ext_p_q;
  assign pre_full = (pre_q == pre_limit(ctrl_q.prescale));
  assign cnt_inc = cnt_q + 16'h0001;
  assign ovf = tick & (cnt_q == 16'hffff);

  // count clock selection and prescaler
  always_comb
  begin
    idiv_d = idiv_q + 2'h1;
    unique case (ctrl_q.source)
      STC_SRC_SYS: ps_d = 1'b1;
      STC_SRC_INSTR: ps_d = (idiv_q == 2'(`STC_INSTR_DIV - 1));
      STC_SRC_EXT: ps_d = ext_rise;
      default: ps_d = 1'b0;
    endcase
    ps_d = ps_d & ctrl_q.run;
    pre_d = pre_q;
    tick = 1'b0;
    if (ps_q)
    begin
      pre_d = pre_full ? 3'h0 : pre_q + 3'h1;
      tick = pre_full & ctrl_q.run;
    end
    if (wr_ctrl)
      pre_d = 3'h0; // a new divide ratio starts from a clean count
  end

  // registers, counter and byte buffers
  always_comb
  begin
    ctrl_d = wr_ctrl ? stc_ctrl_type'(wbyte) : ctrl_q;
    mask_d = wr_mask ? wbyte[`STC_OVF_BIT] : mask_q;
    hbuf_d = rd_lo ? cnt_q[15:8] : hbuf_q;
    wbuf_d = (wr_hi & ctrl_q.wide) ? wbyte : wbuf_q;
    cnt_d = tick ? cnt_inc : cnt_q;
    if (wr_lo)
      cnt_d = ctrl_q.wide ? {wbuf_q, wbyte} : {cnt_q[15:8], wbyte};
    else if (wr_hi & ~ctrl_q.wide)
      cnt_d = {wbyte, cnt_q[7:0]};
    if (special_event_trigger)
      cnt_d = 16'h0000;
    stat_d = (stat_q & ~(wr_stat & wbyte[`STC_OVF_BIT])) | ovf;
    crys_d = ctrl_q.osc_en | companion_oscillator_enable;
    alt_d = crys_d & low_power_crystal_osc;
  end

  // read data and waitrequest
  always_comb
  begin
    rdata_d = rdata_q;
    bus_d = STC_BUS_IDLE;
    wait_d = 1'b1;
    if (req)
    begin
      bus_d = STC_BUS_ACK;
      wait_d = 1'b0;
      rdata_d = 32'h0;
      unique case (avs_address)
        `STC_CTRL_IDX: rdata_d[7:0] = ctrl_q;
        `STC_CNTL_IDX: rdata_d[7:0] = cnt_q[7:0];
        `STC_CNTH_IDX: rdata_d[7:0] = ctrl_q.wide ? hbuf_q : cnt_q[15:8];
        `STC_STAT_IDX: rdata_d[0] = stat_q;
        `STC_MASK_IDX: rdata_d[0] = mask_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      bus_q <= STC_BUS_IDLE;
      wait_q <= 1'b1;
      ctrl_q <= stc_ctrl_type'(`STC_CTRL_RST);
      cnt_q <= 16'h0000;
      hbuf_q <= 8'h00;
      wbuf_q <= 8'h00;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      rdata_q <= 32'h0;
      ps_q <= 1'b0;
      pre_q <= 3'h0;
      idiv_q <= 2'h0;
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
      ext_p_q <= 1'b0;
      crys_q <= 1'b0;
      alt_q <= 1'b0;
    end
    else
    begin
      bus_q <= bus_d;
      wait_q <= wait_d;
      ctrl_q <= ctrl_d;
      cnt_q <= cnt_d;
      hbuf_q <= hbuf_d;
      wbuf_q <= wbuf_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      ps_q <= ps_d;
      pre_q <= pre_d;
      idiv_q <= idiv_d;
      ext_m_q <= ext_raw;
      ext_s_q <= ext_m_q;
      ext_p_q <= ext_in; // last level for the edge detect
      crys_q <= crys_d;
      alt_q <= alt_d;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign count = cnt_q;
  assign crystal_driver_power = crys_q;
  assign alt_sys_clock_source = alt_q;
  // level interrupt, high while flag and mask are both set
  logic irq_q;
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= stat_d & mask_d;
  end
  assign irq = irq_q;

  // assertions
  property p_clear;
    @(posedge clk_sys) disable iff (!nrst)
      special_event_trigger |=> (cnt_q == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("trigger did not clear count");

  property p_stop;
    @(posedge clk_sys) disable iff (!nrst)
      (!ctrl_q.run && !wr_lo && !wr_hi && !special_event_trigger) |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_sys;
    @(posedge clk_sys) disable iff (!nrst)
      (ctrl_q.run && ctrl_q.source == STC_SRC_SYS && ctrl_q.prescale == 2'b00 && !wr_ctrl)
      ##1 (ctrl_q.run && !wr_lo && !wr_hi && !special_event_trigger)
      |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_sys: assert property (p_sys) else $error("system clock count missing");

  property p_pre;
    @(posedge clk_sys) disable iff (!nrst)
      tick |-> (pre_q == pre_limit(ctrl_q.prescale));
  endproperty
  a_pre: assert property (p_pre) else $error("prescaler tick wrong");

  property p_ovf;
    @(posedge clk_sys) disable iff (!nrst)
      ovf |=> stat_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");

  property p_crys;
    @(posedge clk_sys) disable iff (!nrst)
      ##1 1'b1 |-> (crystal_driver_power == $past(ctrl_q.osc_en | companion_oscillator_enable));
  endproperty
  a_crys: assert property (p_crys) else $error("crystal power wrong");

  property p_wide;
    @(posedge clk_sys) disable iff (!nrst)
      (wr_hi && ctrl_q.wide && !special_event_trigger && !tick) |=> $stable(cnt_q[15:8]);
  endproperty
  a_wide: assert property (p_wide) else $error("wide high write not buffered");

  property p_irq;
    @(posedge clk_sys) disable iff (!nrst)
      (stat_q && mask_q) |-> ##[0:1] irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  // an unsynchronized pin edge reaches the counter one cycle later
  property p_unsync;
    @(posedge clk_sys) disable iff (!nrst)
      (ctrl_q.run && ctrl_q.source == STC_SRC_EXT && ctrl_q.sync_n && !ctrl_q.osc_en
       && ctrl_q.prescale == 2'b00 && !wr_ctrl && external_count_pin && !ext_p_q) |=> tick;
  endproperty
  a_unsync: assert property (p_unsync) else $error("unsynchronized edge not counted");

  // a synchronized edge reaches the counter two cycles after the first flop
  property p_sync;
    @(posedge clk_sys) disable iff (!nrst)
      (ctrl_q.run && ctrl_q.source == STC_SRC_EXT && !ctrl_q.sync_n
       && ctrl_q.prescale == 2'b00 && !wr_ctrl && ext_m_q && !ext_s_q)
      ##1 !wr_ctrl |=> tick;
  endproperty
  a_sync: assert property (p_sync) else $error("synchronized edge not counted");

  // every request is answered after exactly one wait cycle
  property p_wait;
    @(posedge clk_sys) disable iff (!nrst)
      ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("request not answered");

  // alternate clock follows the crystal only while its driver is powered
  property p_alt;
    @(posedge clk_sys) disable iff (!nrst)
      1'b1 |=> alt_sys_clock_source
        == $past((ctrl_q.osc_en | companion_oscillator_enable) & low_power_crystal_osc);
  endproperty
  a_alt: assert property (p_alt) else $error("alternate clock wrong");

  // main scenarios
  c_ovf: cover property (@(posedge clk_sys) disable iff (!nrst) ovf);
  c_unsync: cover property (@(posedge clk_sys) disable iff (!nrst) tick && ctrl_q.sync_n);
  c_xtal: cover property (@(posedge clk_sys) disable iff (!nrst) tick && ctrl_q.osc_en);
  c_trig: cover property (@(posedge clk_sys) disable iff (!nrst) special_event_trigger);
  c_wide: cover property (@(posedge clk_sys) disable iff (!nrst) wr_lo && ctrl_q.wide);
endmodule

// >>> tb/stc_ext_model.sv
// far-side clock sources: external count pin and low-power crystal
`timescale 1ns/1ps
module stc_ext_model (
  input wire logic clk_sys,
  input wire logic crystal_driver_power,
  output logic external_count_pin,
  output logic low_power_crystal_osc
);
  initial
  begin
    external_count_pin = 1'b0;
    low_power_crystal_osc = 1'b0;
  end
  // n slow pin pulses, three system cycles per half period
  task automatic pin_burst(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk_sys);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      external_count_pin <= 1'b0;
    end
  endtask
  // crystal held at a level, only while its driver is powered
  task automatic xtal_hold(input logic v);
    low_power_crystal_osc <= v & crystal_driver_power;
  endtask
  // crystal swings only while its driver is powered
  task automatic xtal_burst(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clk_sys);
      low_power_crystal_osc <= crystal_driver_power;
      repeat (3) @(posedge clk_sys);
      low_power_crystal_osc <= 1'b0;
    end
  endtask
endmodule

// >>> tb/tb_stc_timer.sv
// self-checking bench for the timer against an integer count model
`timescale 1ns/1ps
`include "stc_regs.svh"
module tb_stc_timer;
  import stc_pkg::*;
  logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest, irq, pin, xtal;
  logic special_event_trigger, companion_oscillator_enable, crystal_driver_power, alt_src;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [31:0] lfsr_q = 32'habd5;
  logic [15:0] count, m_cnt;
  int num_errors, total_checks, cyc;
  stc_timer i_stc_timer (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_count_pin(pin), .low_power_crystal_osc(xtal),
    .special_event_trigger(special_event_trigger),
    .companion_oscillator_enable(companion_oscillator_enable),
    .crystal_driver_power(crystal_driver_power), .alt_sys_clock_source(alt_src),
    .count(count), .irq(irq));
  stc_ext_model i_stc_ext_model (.clk_sys(clk_sys),
    .crystal_driver_power(crystal_driver_power),
    .external_count_pin(pin), .low_power_crystal_osc(xtal));
  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic ctl(input logic [7:0] v);
    bus(`STC_CTRL_IDX, 1'b1, v);
  endtask
  task automatic setcnt(input logic [15:0] v);
    bus(`STC_CNTL_IDX, 1'b1, v[7:0]);
    bus(`STC_CNTH_IDX, 1'b1, v[15:8]);
    m_cnt = v;
  endtask
  task automatic trig();
    special_event_trigger <= 1'b1;
    @(posedge clk_sys);
    special_event_trigger <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial
  begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    special_event_trigger = 1'b0;
    companion_oscillator_enable = 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    bus(`STC_CTRL_IDX, 1'b0, 8'h00);
    chk(rdv, {24'h0, `STC_CTRL_RST});
    bus(12'h100, 1'b1, 8'hff);
    bus(12'h100, 1'b0, 8'h00);
    chk(rdv, 32'h0);
    // random bytes written and read back
    repeat (4)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      setcnt(lfsr_q[15:0]);
      bus(`STC_CNTH_IDX, 1'b0, 8'h00);
      chk(rdv, {24'h0, m_cnt[15:8]});
      chk(count, m_cnt);
    end
    // pin pulses through every prescale, synced and not
    for (int k = 0; k < 8; k++)
    begin
      ctl({2'b10, k[2:1], 1'b0, k[0], 2'b01});
      i_stc_ext_model.pin_burst(16);
      repeat (4) @(posedge clk_sys);
      ctl(8'h80);
      m_cnt = m_cnt + 16'(16 >> k[2:1]);
      chk(count, m_cnt);
    end
    i_stc_ext_model.pin_burst(8);
    chk(count, m_cnt);
    // crystal powered: pin ignored, crystal edges counted
    ctl(8'h89);
    i_stc_ext_model.pin_burst(8);
    i_stc_ext_model.xtal_burst(8);
    repeat (4) @(posedge clk_sys);
    ctl(8'h88);
    m_cnt = m_cnt + 16'd8;
    chk(count, m_cnt);
    chk(alt_src, xtal);
    i_stc_ext_model.xtal_hold(1'b1);
    repeat (2) @(posedge clk_sys);
    chk(alt_src, 1'b1);
    i_stc_ext_model.xtal_hold(1'b0);
    for (int k = 0; k < 4; k++)
    begin
      companion_oscillator_enable <= k[1];
      ctl({4'h0, k[0], 3'b000});
      repeat (2) @(posedge clk_sys);
      chk(crystal_driver_power, 32'(k[0] | k[1]));
    end
    trig();
    chk(count, 16'h0);
    // wide mode: high byte buffered, low read latches high
    ctl(8'h02);
    lfsr_q = lfsr_next(lfsr_q);
    bus(`STC_CNTH_IDX, 1'b1, lfsr_q[15:8]);
    chk(count, 16'h0);
    bus(`STC_CNTL_IDX, 1'b1, lfsr_q[7:0]);
    chk(count, lfsr_q[15:0]);
    bus(`STC_CNTL_IDX, 1'b0, 8'h00);
    chk(rdv, {24'h0, lfsr_q[7:0]});
    trig();
    bus(`STC_CNTH_IDX, 1'b0, 8'h00);
    chk(rdv, {24'h0, lfsr_q[15:8]});
    // free clocks over a fixed window; system clock used without capture
    for (int k = 0; k < 2; k++)
    begin
      ctl(8'h00);
      setcnt(16'h0000);
      ctl(k ? 8'h71 : 8'h01);
      repeat (80) @(posedge clk_sys);
      ctl(8'h00);
      chk(32'(count >= (k ? 10 : 20) && count <= (k ? 11 : 22)), 32'h1);
    end
    // overflow sets sticky flag, mask gates irq, write one clears
    setcnt(16'hfffe);
    bus(`STC_STAT_IDX, 1'b1, 8'h01);
    bus(`STC_MASK_IDX, 1'b1, 8'h01);
    ctl(8'h41);
    ctl(8'h40);
    bus(`STC_STAT_IDX, 1'b0, 8'h00);
    chk(rdv[0], 1'b1);
    chk(irq, 1'b1);
    bus(`STC_MASK_IDX, 1'b1, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    bus(`STC_STAT_IDX, 1'b1, 8'h01);
    bus(`STC_MASK_IDX, 1'b1, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    end_sim();
  end
endmodule
